// ### hdl/cbps_pkg.sv
// Package of constants and types for the bus parity and inquire controller.
package cbps_pkg;

  // ---------------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------------
  localparam int unsigned DATA_W      = 64;
  localparam int unsigned LANES       = 8;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned BURST_BEATS = 4;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned BEAT_W      = 2;
  localparam int unsigned ARM_W       = 2;

  // Edges after a bus grant before the inquire strobe is looked at.
  localparam logic [ARM_W-1:0] INQ_ARM_EDGES = 2'h2;
  // Edges after an address strobe during which the inquire strobe is ignored.
  localparam logic [ARM_W-1:0] ADS_BLOCK_EDGES = 2'h2;
  localparam logic [BEAT_W-1:0] LAST_BEAT = 2'h3;

  // Bit of the extended feature register that masks the buffer-empty input.
  localparam int unsigned EFR_WBE_MASK_BIT = 3;
  localparam int unsigned EFR_W            = 8;

  // Write-data FIFO entry: data plus lane enables.
  localparam int unsigned WFIFO_W = DATA_W + LANES;

  // Bus cycle state.
  typedef enum logic [1:0] {
    CBPS_IDLE,
    CBPS_WRITE,
    CBPS_READ
  } cbps_cyc_t;

endpackage : cbps_pkg

// ### hdl/cbps_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module cbps_fifo #(
  parameter int unsigned WIDTH = 72,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // Handshakes on each side.
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];

  // Storage write.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule : cbps_fifo
`default_nettype wire

// ### hdl/cbps_ctrl.sv
// Data parity, inquire, buffer-empty, float error and flush control.
`timescale 1ns/1ps
`default_nettype none
module cbps_ctrl (
  // Clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             rst_n_i,
  // Core write data feed
  input  wire logic                             wr_valid_i,
  output logic                                  wr_ready_o,
  input  wire logic [cbps_pkg::DATA_W-1:0]      wr_data_i,
  input  wire logic [cbps_pkg::LANES-1:0]       wr_lane_en_i,
  // Core cycle start
  input  wire logic                             cyc_start_i,
  input  wire logic                             cyc_write_i,
  input  wire logic                             cyc_burst_i,
  input  wire logic                             cyc_wbe_kind_i,
  // Bus pins
  input  wire logic                             address_strobe_n_i,
  input  wire logic                             burst_ready_n_i,
  input  wire logic                             back_off_n_i,
  input  wire logic                             address_hold_i,
  input  wire logic                             hold_grant_i,
  input  wire logic                             addr_drive_i,
  input  wire logic [cbps_pkg::LANES-1:0]       byte_lane_enables_n_i,
  input  wire logic [cbps_pkg::DATA_W-1:0]      data_in_i,
  input  wire logic [cbps_pkg::LANES-1:0]       byte_parity_bits_i,
  output logic      [cbps_pkg::LANES-1:0]       byte_parity_bits_o,
  output logic                                  byte_parity_bits_oe_o,
  output logic      [cbps_pkg::DATA_W-1:0]      data_out_o,
  output logic                                  parity_error_out_n_o,
  // Inquire
  input  wire logic                             inquire_strobe_n_i,
  input  wire logic                             cache_valid_i,
  input  wire logic                             cache_modified_i,
  output logic                                  inquire_hit_n_o,
  output logic                                  inquire_hit_modified_n_o,
  output logic                                  inquire_take_o,
  // Write buffer empty
  input  wire logic                             ext_write_buffer_empty_n_i,
  input  wire logic [cbps_pkg::EFR_W-1:0]       extended_feature_register_i,
  output logic                                  wbe_defer_o,
  // Floating point error
  input  wire logic                             float_fault_i,
  input  wire logic                             float_boundary_i,
  input  wire logic                             float_clear_i,
  output logic                                  float_error_n_o,
  // Flush and test mode
  input  wire logic                             flush_n_i,
  input  wire logic                             reset_pin_i,
  input  wire logic                             instr_boundary_i,
  input  wire logic                             flush_done_i,
  output logic                                  flush_run_o,
  output logic                                  flush_ack_cycle_o,
  output logic                                  test_mode_o
);

  // -----------------------------------------------------------------------
  // Pin samples
  // -----------------------------------------------------------------------
  logic ready_s;
  logic back_off_n_s;
  logic ads_s;
  logic inquire_strobe_n_s;

  assign ready_s = !burst_ready_n_i;
  assign back_off_n_s  = !back_off_n_i;
  assign ads_s   = !address_strobe_n_i;
  assign inquire_strobe_n_s  = !inquire_strobe_n_i;

  // -----------------------------------------------------------------------
  // Bus cycle tracking
  // -----------------------------------------------------------------------
  cbps_pkg::cbps_cyc_t         cyc_r;
  logic                        burst_r;
  logic                        wbe_kind_r;
  logic [cbps_pkg::BEAT_W-1:0] beat_r;
  logic                        last_beat;

  assign last_beat = !burst_r || (beat_r == cbps_pkg::LAST_BEAT);

  // Cycle state follows the address strobe and counts ready beats.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_r      <= cbps_pkg::CBPS_IDLE;
      burst_r    <= 1'b0;
      wbe_kind_r <= 1'b0;
      beat_r     <= '0;
    end else begin
      case (cyc_r)
        cbps_pkg::CBPS_IDLE: begin
          if (cyc_start_i && ads_s) begin
            cyc_r      <= cyc_write_i ? cbps_pkg::CBPS_WRITE
                                      : cbps_pkg::CBPS_READ;
            burst_r    <= cyc_burst_i;
            wbe_kind_r <= cyc_wbe_kind_i;
            beat_r     <= '0;
          end
        end
        cbps_pkg::CBPS_WRITE, cbps_pkg::CBPS_READ: begin
          if (back_off_n_s) begin
            cyc_r <= cbps_pkg::CBPS_IDLE; // Aborted; core restarts it.
          end else if (ready_s) begin
            beat_r <= beat_r + 1'b1;
            if (last_beat) begin
              cyc_r <= cbps_pkg::CBPS_IDLE;
            end
          end
        end
        default: begin
          cyc_r <= cbps_pkg::CBPS_IDLE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Write data buffer
  // -----------------------------------------------------------------------
  logic                                wf_valid;
  logic                                wf_pop;
  logic [cbps_pkg::WFIFO_W-1:0]        wf_data;
  logic                                wr_start;
  logic                                wr_beat;

  // The head moves to the pins at the write strobe and on each ready but
  // the last; a back-off drops words already taken, so the core resends.
  assign wr_start = (cyc_r == cbps_pkg::CBPS_IDLE) && cyc_start_i && ads_s &&
                    cyc_write_i;
  assign wr_beat  = (cyc_r == cbps_pkg::CBPS_WRITE) && ready_s && !back_off_n_s &&
                    !last_beat;
  assign wf_pop   = wf_valid && (wr_start || wr_beat);

  cbps_fifo #(
    .WIDTH (cbps_pkg::WFIFO_W),
    .DEPTH (cbps_pkg::FIFO_DEPTH)
  ) u_wfifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (wr_valid_i),
    .in_ready_o  (wr_ready_o),
    .in_data_i   ({wr_lane_en_i, wr_data_i}),
    .out_valid_o (wf_valid),
    .out_ready_i (wf_pop),
    .out_data_o  (wf_data)
  );

  // -----------------------------------------------------------------------
  // Parity generation and checking
  // -----------------------------------------------------------------------
  logic [cbps_pkg::LANES-1:0] gen_par;
  logic [cbps_pkg::LANES-1:0] bad_lane;
  logic [cbps_pkg::LANES-1:0] out_lane_en;

  assign out_lane_en = wf_data[cbps_pkg::WFIFO_W-1:cbps_pkg::DATA_W];

  // Per-lane even parity on both directions.
  for (genvar n = 0; n < cbps_pkg::LANES; n++) begin : g_lane
    // Lane n covers bits 8n+7 down to 8n.
    assign gen_par[n] =
      ^wf_data[n*cbps_pkg::BYTE_W +: cbps_pkg::BYTE_W];
    assign bad_lane[n] = !byte_lane_enables_n_i[n] &&
      (^{data_in_i[n*cbps_pkg::BYTE_W +: cbps_pkg::BYTE_W],
         byte_parity_bits_i[n]});
  end

  // Parity and data drive, updated after strobe and on each ready but the last.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byte_parity_bits_o    <= '0;
      data_out_o            <= '0;
      byte_parity_bits_oe_o <= 1'b0;
    end else begin
      if (back_off_n_s || hold_grant_i) begin
        byte_parity_bits_oe_o <= 1'b0;
      end else if (cyc_r == cbps_pkg::CBPS_WRITE &&
                   !(ready_s && last_beat)) begin
        byte_parity_bits_oe_o <= 1'b1;
      end else begin
        byte_parity_bits_oe_o <= 1'b0;
      end
      // Pins take the buffer head only when it is popped.
      if (wf_pop) begin
        byte_parity_bits_o <= gen_par & out_lane_en;
        data_out_o         <= wf_data[cbps_pkg::DATA_W-1:0];
      end
    end
  end

  // Check pulse one clock after the read beat; no exception is raised.
  // Disabled lanes never reach the reduction.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      parity_error_out_n_o <= 1'b1;
    end else begin
      parity_error_out_n_o <= !((cyc_r == cbps_pkg::CBPS_READ) && ready_s &&
                                !back_off_n_s && (|bad_lane));
    end
  end

  // -----------------------------------------------------------------------
  // Inquire strobe qualification
  // -----------------------------------------------------------------------
  logic [cbps_pkg::ARM_W-1:0] arm_cnt_r;
  logic [cbps_pkg::ARM_W-1:0] ads_blk_r;
  logic                       inquire_strobe_n_d_r;
  logic                       taken_bus;
  logic                       inq_ok;

  // The other party owns the address bus before it strobes.
  assign taken_bus = address_hold_i || back_off_n_s || hold_grant_i;
  assign inq_ok = inquire_strobe_n_s && (arm_cnt_r == cbps_pkg::INQ_ARM_EDGES) &&
                  !inquire_strobe_n_d_r && (ads_blk_r == '0) && !addr_drive_i &&
                  inquire_hit_modified_n_o;

  // Arming counter, strobe echo and address-strobe blackout.
  // A hold grant arms like address hold, from its first edge.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arm_cnt_r <= '0;
      ads_blk_r <= '0;
      inquire_strobe_n_d_r  <= 1'b0;
    end else begin
      inquire_strobe_n_d_r  <= inq_ok;
      if (!taken_bus) begin
        arm_cnt_r <= '0;
      end else if (arm_cnt_r != cbps_pkg::INQ_ARM_EDGES) begin
        arm_cnt_r <= arm_cnt_r + 1'b1;
      end
      if (ads_s) begin
        ads_blk_r <= cbps_pkg::ADS_BLOCK_EDGES;
      end else if (ads_blk_r != '0) begin
        ads_blk_r <= ads_blk_r - 1'b1;
      end
    end
  end

  // Hit outputs change only the edge after an accepted inquire.
  // A refused strobe leaves both hit outputs as they were.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inquire_hit_n_o          <= 1'b1;
      inquire_hit_modified_n_o <= 1'b1;
      inquire_take_o           <= 1'b0;
    end else begin
      inquire_take_o <= inq_ok;
      if (inq_ok) begin
        inquire_hit_n_o          <= !cache_valid_i;
        inquire_hit_modified_n_o <= !(cache_valid_i && cache_modified_i);
      end
    end
  end

  // -----------------------------------------------------------------------
  // External write buffer empty
  // -----------------------------------------------------------------------
  logic wbe_mask;
  logic wbe_look;

  assign wbe_mask = extended_feature_register_i[cbps_pkg::EFR_WBE_MASK_BIT];
  assign wbe_look = (cyc_r == cbps_pkg::CBPS_WRITE) && wbe_kind_r &&
                    ready_s && !back_off_n_s;

  // Defer flag set on a negated sample, cleared once seen asserted.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wbe_defer_o <= 1'b0;
    end else if (wbe_mask) begin
      wbe_defer_o <= 1'b0;
    end else if (wbe_look || wbe_defer_o) begin
      wbe_defer_o <= ext_write_buffer_empty_n_i;
    end
  end

  // -----------------------------------------------------------------------
  // Floating point error
  // -----------------------------------------------------------------------
  logic fp_pend_r;

  // Fault is held pending and shown at the next float boundary.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fp_pend_r       <= 1'b0;
      float_error_n_o <= 1'b1;
    end else begin
      if (float_clear_i) begin
        fp_pend_r       <= float_fault_i;
        float_error_n_o <= 1'b1;
      end else begin
        if (float_fault_i) begin
          fp_pend_r <= 1'b1;
        end else if (float_boundary_i) begin
          fp_pend_r <= 1'b0;
        end
        if (float_boundary_i && fp_pend_r) begin
          float_error_n_o <= 1'b0;
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // Flush and test mode
  // -----------------------------------------------------------------------
  logic flush_d_r;
  logic flush_pend_r;

  // Falling-edge latch, taken at a boundary; acknowledge after the flush.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flush_d_r         <= 1'b1;
      flush_pend_r      <= 1'b0;
      flush_run_o       <= 1'b0;
      flush_ack_cycle_o <= 1'b0;
    end else begin
      flush_d_r         <= flush_n_i;
      flush_ack_cycle_o <= 1'b0;
      if (flush_d_r && !flush_n_i && !reset_pin_i) begin
        flush_pend_r <= 1'b1;
      end else if (flush_pend_r && instr_boundary_i) begin
        flush_pend_r <= 1'b0;
      end
      if (flush_pend_r && instr_boundary_i) begin
        flush_run_o <= 1'b1;
      end else if (flush_run_o && flush_done_i) begin
        flush_run_o       <= 1'b0;
        flush_ack_cycle_o <= 1'b1;
      end
    end
  end

  // Flush level sampled on every edge the reset pin is high; the last
  // sample, on the edge before release is seen, decides test mode.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      test_mode_o <= 1'b0;
    end else begin
      if (reset_pin_i) begin
        test_mode_o <= !flush_n_i;
      end
    end
  end

endmodule : cbps_ctrl
`default_nettype wire

// ### dv/cbps_ctrl_assertions.sv
// Port timing checker for the parity and inquire controller.
`timescale 1ns/1ps
`default_nettype none
module cbps_ctrl_chk (
  // Clock and reset
  input wire logic                         clk_i,
  input wire logic                         rst_n_i,
  // Bus inputs
  input wire logic                         address_strobe_n_i,
  input wire logic                         cyc_start_i,
  input wire logic                         cyc_write_i,
  input wire logic                         burst_ready_n_i,
  input wire logic                         back_off_n_i,
  input wire logic                         hold_grant_i,
  // Inquire, flags and float inputs
  input wire logic                         inquire_strobe_n_i,
  input wire logic                         cache_valid_i,
  input wire logic [cbps_pkg::EFR_W-1:0]   extended_feature_register_i,
  input wire logic                         float_boundary_i,
  input wire logic                         float_clear_i,
  // Watched outputs
  input wire logic [cbps_pkg::LANES-1:0]   byte_parity_bits_o,
  input wire logic                         byte_parity_bits_oe_o,
  input wire logic                         parity_error_out_n_o,
  input wire logic                         inquire_hit_n_o,
  input wire logic                         inquire_take_o,
  input wire logic                         wbe_defer_o,
  input wire logic                         float_error_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ---------------------------------------------------------------------
  // Parity pins
  // ---------------------------------------------------------------------
  a_perr_cause : assert property (
    !parity_error_out_n_o |-> $past(!burst_ready_n_i && back_off_n_i))
    else $error("Parity error flagged without a read beat.");
  a_perr_once : assert property (
    !parity_error_out_n_o && burst_ready_n_i |=> parity_error_out_n_o)
    else $error("Parity error held longer than one clock.");
  a_oe_start : assert property (
    $rose(byte_parity_bits_oe_o) |->
      $past(!address_strobe_n_i && cyc_start_i && cyc_write_i, 2))
    else $error("Parity driven without a write strobe.");
  a_par_hold : assert property (
    byte_parity_bits_oe_o && burst_ready_n_i && back_off_n_i &&
      !hold_grant_i |=> $stable(byte_parity_bits_o))
    else $error("Write parity changed without a ready beat.");
  a_par_float : assert property (
    !back_off_n_i || hold_grant_i |=> !byte_parity_bits_oe_o)
    else $error("Parity pins not floated on back-off or grant.");

  // ---------------------------------------------------------------------
  // Inquire, buffer-empty and float error
  // ---------------------------------------------------------------------
  a_hit_cause : assert property (
    $changed(inquire_hit_n_o) |-> $past(!inquire_strobe_n_i))
    else $error("Hit output changed without an inquire.");
  a_hit_value : assert property (
    $changed(inquire_hit_n_o) |-> inquire_hit_n_o == !$past(cache_valid_i))
    else $error("Hit output disagrees with the lookup.");
  a_inq_gap : assert property (
    inquire_take_o |=> !inquire_take_o)
    else $error("Inquire taken on the edge after another.");
  a_wbe_mask : assert property (
    extended_feature_register_i[3] |=> !wbe_defer_o)
    else $error("Defer raised while buffer-empty is masked.");
  a_float_error_n_set : assert property (
    $fell(float_error_n_o) |-> $past(float_boundary_i))
    else $error("Float error raised off a boundary.");
  a_float_error_n_clr : assert property (
    float_clear_i |=> float_error_n_o)
    else $error("Float error not negated after a clear.");

  // Main scenarios reached.
  c_perr : cover property (!parity_error_out_n_o);
  c_take : cover property (inquire_take_o);
  c_defer : cover property (wbe_defer_o);
endmodule : cbps_ctrl_chk

bind cbps_ctrl cbps_ctrl_chk u_chk (.*);
`default_nettype wire

// ### dv/cbps_sys_model.sv
// System logic model: gives ready beats and read data with parity.
`timescale 1ns/1ps
`default_nettype none
module cbps_sys_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Cycle request from the bench
  input  wire logic        run_i,
  input  wire logic [2:0]  beats_i,
  input  wire logic [1:0]  waits_i,
  input  wire logic [7:0]  wrong_lane_i,
  // Bus side
  output logic             burst_ready_n_o,
  output logic      [63:0] data_o,
  output logic      [7:0]  parity_o
);
  logic [2:0]  left_r;
  logic [1:0]  wait_r;
  logic [63:0] d;

  // Even parity of each byte lane.
  function automatic logic [7:0] epar(input logic [63:0] v);
    for (int i = 0; i < 8; i++) epar[i] = ^v[8*i +: 8];
  endfunction : epar

  // Wait states, then one ready per beat; released lines toggle.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_r <= 3'h0;
      wait_r <= 2'h0;
      burst_ready_n_o <= 1'b1;
      data_o <= 64'h0;
      parity_o <= 8'h0;
    end else begin
      burst_ready_n_o <= 1'b1;
      data_o <= ~data_o;
      parity_o <= ~parity_o;
      if (run_i) begin
        left_r <= beats_i;
        wait_r <= waits_i;
      end else if (left_r != 3'h0) begin
        if (wait_r != 2'h0) begin
          wait_r <= wait_r - 2'h1;
        end else begin
          d = {$urandom, $urandom};
          burst_ready_n_o <= 1'b0;
          data_o <= d;
          parity_o <= epar(d) ^ wrong_lane_i;
          left_r <= left_r - 3'h1;
          wait_r <= waits_i;
        end
      end
    end
  end
endmodule : cbps_sys_model
`default_nettype wire

// ### dv/tb_cbps_ctrl.sv
// Self-checking bench for the parity, inquire and flag controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  checks_done++; \
  if ((a) !== (b)) begin \
    bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end
module tb_cbps_ctrl;
  logic clk_i = 1'b0, rst_n_i = 1'b0, wr_valid_i = 1'b0, wr_ready_o;
  logic [63:0] wr_data_i = 64'h0, data_in_i, data_out_o;
  logic [7:0] wr_lane_en_i = 8'hff, byte_lane_enables_n_i = 8'h0;
  logic [7:0] byte_parity_bits_i, byte_parity_bits_o, wrong_lane = 8'h0;
  logic [7:0] extended_feature_register_i = 8'h0;
  logic cyc_start_i = 0, cyc_write_i = 0, cyc_burst_i = 0;
  logic cyc_wbe_kind_i = 0, address_strobe_n_i = 1, back_off_n_i = 1;
  logic burst_ready_n_i, address_hold_i = 0, hold_grant_i = 0;
  logic addr_drive_i = 0, byte_parity_bits_oe_o, parity_error_out_n_o;
  logic inquire_strobe_n_i = 1, cache_valid_i = 0, cache_modified_i = 0;
  logic inquire_hit_n_o, inquire_hit_modified_n_o, inquire_take_o;
  logic ext_write_buffer_empty_n_i = 0, wbe_defer_o, float_error_n_o;
  logic float_fault_i = 0, float_boundary_i = 0, float_clear_i = 0;
  logic flush_n_i = 1, reset_pin_i = 0, instr_boundary_i = 0;
  logic flush_done_i = 0, flush_run_o, flush_ack_cycle_o, test_mode_o;
  logic run = 0, rd_cyc = 0, rd_beat = 0;
  logic [2:0] beats = 3'h0;
  logic [1:0] waits = 2'h0;
  int bad_count = 0, checks_done = 0, cycles = 0, k;
  logic [71:0] dq[$];
  logic [79:0] qpar[$];
  logic qerr[$];

  cbps_ctrl dut (.*);
  cbps_sys_model u_sys (.clk_i, .rst_n_i, .run_i(run), .beats_i(beats),
    .waits_i(waits), .wrong_lane_i(wrong_lane),
    .burst_ready_n_o(burst_ready_n_i), .data_o(data_in_i),
    .parity_o(byte_parity_bits_i));

  // Clock at 200 MHz.
  initial forever #2.5 clk_i = ~clk_i;

  function automatic logic [7:0] epar(input logic [63:0] v);
    for (int i = 0; i < 8; i++) epar[i] = ^v[8*i +: 8];
  endfunction : epar

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task summarize;
    $display("checks=%0d bad=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // Fill the write buffer with random words and lane enables.
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      wr_valid_i = 1'b1;
      wr_data_i = {$urandom, $urandom};
      wr_lane_en_i = 8'($urandom);
      dq.push_back({wr_lane_en_i, wr_data_i});
      tick();
    end
    wr_valid_i = 1'b0;
  endtask : push

  // One bus cycle; expected results are noted before the strobe.
  task automatic cyc(input logic wr, bst, kind, input logic [1:0] w);
    logic [71:0] e;
    beats = bst ? 3'h4 : 3'h1;
    waits = w;
    for (int i = 0; i < beats; i++) begin
      if (wr) begin
        e = dq.pop_front();
        qpar.push_back({e[71:64], epar(e[63:0]) & e[71:64], e[63:0]});
      end else qerr.push_back(|(wrong_lane & ~byte_lane_enables_n_i));
    end
    rd_cyc = !wr;
    {address_strobe_n_i, cyc_start_i, run} = 3'b011;
    {cyc_write_i, cyc_burst_i, cyc_wbe_kind_i} = {wr, bst, kind};
    tick();
    {address_strobe_n_i, cyc_start_i, run} = 3'b100;
    for (k = 0; k < 40 && qpar.size() + qerr.size() != 0; k++) tick();
    tick(2);
    rd_cyc = 1'b0;
  endtask : cyc

  // Result watcher: takes the oldest note whenever a beat result shows.
  always @(posedge clk_i) begin
    logic [79:0] e;
    if (rst_n_i) begin
      if (byte_parity_bits_oe_o === 1'b1 && burst_ready_n_i === 1'b0 &&
          back_off_n_i) begin
        e = qpar.size() != 0 ? qpar.pop_front() : 'x;
        `CHK(byte_parity_bits_o & e[79:72], e[71:64])
        `CHK(data_out_o, e[63:0])
      end
      if (rd_beat) begin
        e[0] = qerr.size() != 0 ? !qerr.pop_front() : 1'bx;
        `CHK(parity_error_out_n_o, e[0])
      end
      rd_beat <= rd_cyc && !burst_ready_n_i && back_off_n_i;
      cycles++;
      if (cycles == 5000) begin
        bad_count++;
        summarize();
      end
    end
  end

  // Main sequence.
  initial begin
    void'($urandom(34));
    tick(8);
    rst_n_i = 1'b1;
    tick();
    push(16);
    `CHK(wr_ready_o, 1'b0)
    for (int i = 0; i < 4; i++) cyc(1'b1, 1'b1, 1'b0, 2'(i));
    $display("test fill_drain_bursts done");
    ext_write_buffer_empty_n_i = 1'b1;
    push(1);
    cyc(1'b1, 1'b0, 1'b1, 2'h1);
    `CHK(wbe_defer_o, 1'b1)
    ext_write_buffer_empty_n_i = 1'b0;
    tick();
    `CHK(wbe_defer_o, 1'b0)
    {ext_write_buffer_empty_n_i, extended_feature_register_i} = 9'h108;
    push(1);
    cyc(1'b1, 1'b0, 1'b1, 2'h0);
    `CHK(wbe_defer_o, 1'b0)
    {ext_write_buffer_empty_n_i, extended_feature_register_i} = 9'h000;
    $display("test buffer_empty done");
    for (int i = 0; i < 9; i++) begin
      wrong_lane = 8'h1 << i;
      byte_lane_enables_n_i = 8'($urandom);
      cyc(1'b0, 1'(i % 2), 1'b0, 2'(i % 4));
    end
    $display("test read_parity done");
    {back_off_n_i, hold_grant_i, addr_drive_i} = 3'b011;
    tick();
    {back_off_n_i, hold_grant_i, addr_drive_i} = 3'b100;
    address_hold_i = 1'b1;
    tick(2);
    for (int i = 0; i < 4; i++) begin
      inquire_strobe_n_i = 1'b0;
      cache_valid_i = (i == 1 || i == 2);
      cache_modified_i = (i == 2);
      tick();
      inquire_strobe_n_i = 1'b1;
      `CHK(inquire_hit_n_o, (i == 3) ? 1'b0 : !cache_valid_i)
      `CHK(inquire_hit_modified_n_o, (i < 2))
      `CHK(inquire_take_o, (i < 3))
      tick();
    end
    address_hold_i = 1'b0;
    $display("test inquire done");
    float_fault_i = 1'b1;
    tick();
    float_fault_i = 1'b0;
    tick();
    `CHK(float_error_n_o, 1'b1)
    float_boundary_i = 1'b1;
    tick();
    float_boundary_i = 1'b0;
    `CHK(float_error_n_o, 1'b0)
    float_clear_i = 1'b1;
    tick();
    float_clear_i = 1'b0;
    `CHK(float_error_n_o, 1'b1)
    $display("test float_error done");
    flush_n_i = 1'b0;
    tick();
    flush_n_i = 1'b1;
    instr_boundary_i = 1'b1;
    tick();
    instr_boundary_i = 1'b0;
    for (k = 0; k < 8 && flush_run_o !== 1'b1; k++) tick();
    `CHK(flush_run_o, 1'b1)
    flush_done_i = 1'b1;
    tick();
    flush_done_i = 1'b0;
    for (k = 0; k < 8 && flush_ack_cycle_o !== 1'b1; k++) tick();
    `CHK(flush_ack_cycle_o, 1'b1)
    {reset_pin_i, flush_n_i} = 2'b10;
    tick();
    reset_pin_i = 1'b0;
    tick();
    flush_n_i = 1'b1;
    `CHK(test_mode_o, 1'b1)
    reset_pin_i = 1'b1;
    tick();
    reset_pin_i = 1'b0;
    tick();
    `CHK(test_mode_o, 1'b0)
    $display("test flush_and_test_mode done");
    summarize();
  end
endmodule : tb_cbps_ctrl
`default_nettype wire
